/* File: pkg/ixd_pkg.sv */
/*
  Constants, state codes and small helpers for the indexed postbyte decoder.
  Assumes a single 40 MHz core clock and an AHB-Lite register port.
*/
// Functional notes
// - Postbyte follows opcode, then zero, one or two extension bytes per encoding.
// - base_select 00 first index, 01 second index, 10 stack, 11 program counter.
// - Short form adds signed 5-bit postbyte offset, -16..+15, no extension byte.
// - 111rr0zs with long flag clear: sign bit plus one extension byte, -256..+255.
// - Long flag set, sign clear: 16-bit offset from two extension bytes added to base.
// - Sixteen-bit offset addition wraps modulo 65536; signedness does not matter.
// - 111rr011: base plus 16-bit offset addresses a pointer that becomes operand address.
// - Auto-modify: deferred_change 0 pre, 1 post; 0000..0111 is +1..+8, 1111..1000 is -1..-8.
// - Auto-modify applies only to both index registers and stack pointer, never PC.
// - 111rr1aa: aa 00 and 01 add 8-bit accumulator, 10 adds 16-bit, all unsigned.
// - 111rr111: base plus 16-bit accumulator addresses a pointer used as operand address.
// - Constant-offset forms leave the base register unchanged.
// - Load-effective-address instructions write the address to their target, no access.
// - Stack pointer is legal base everywhere; PC everywhere except auto-modify.
// - Every mode combines a 16-bit register with postbyte data into 16-bit address.
// - Pre-modify accesses with updated value; post-modify accesses original then updates.
// - Sixteen-bit memory values: lower address byte is the high half.
// - PC base equals the address just after the instruction's last byte.
package ixd_pkg;

  // Register offsets (byte addresses)
  localparam logic [7:0] IXD_CTRL_OFS = 8'h00;
  localparam logic [7:0] IXD_STAT_OFS = 8'h04;
  localparam logic [7:0] IXD_EA_OFS   = 8'h08;
  localparam logic [7:0] IXD_CNT_OFS  = 8'h0C;
  localparam int         IXD_CTRL_EN  = 0;
  localparam logic       IXD_EN_RST   = 1'b1;
  localparam int         IXD_ST_BUSY  = 0;
  localparam int         IXD_ST_IND   = 8;
  localparam int         IXD_ST_AUTO  = 9;

  // Postbyte layout
  localparam int         IXD_PB_SHORT = 5;
  localparam int         IXD_PB_PRE   = 4;
  localparam int         IXD_PB_ACC   = 2;
  localparam int         IXD_PB_LONG  = 1;
  localparam logic [2:0] IXD_PB_EXTTAG = 3'h7;

  localparam logic [1:0] IXD_BASE_FIRST  = 2'h0;
  localparam logic [1:0] IXD_BASE_SECOND = 2'h1;
  localparam logic [1:0] IXD_BASE_STACK  = 2'h2;
  localparam logic [1:0] IXD_BASE_PC     = 2'h3;

  localparam logic [1:0] IXD_ACC_A    = 2'h0;
  localparam logic [1:0] IXD_ACC_B    = 2'h1;
  localparam logic [1:0] IXD_ACC_D    = 2'h2;
  localparam logic [1:0] IXD_ACC_DIND = 2'h3;

  localparam logic [1:0] IXD_LEA_NONE   = 2'h0;
  localparam logic [1:0] IXD_LEA_STACK  = 2'h1;
  localparam logic [1:0] IXD_LEA_FIRST  = 2'h2;
  localparam logic [1:0] IXD_LEA_SECOND = 2'h3;

  typedef enum logic [3:0] {
    IXD_IDLE   = 4'h0,
    IXD_GET_PB = 4'h1,
    IXD_EXT1   = 4'h2,
    IXD_EXT2   = 4'h3,
    IXD_CALC   = 4'h4,
    IXD_PTR_HI = 4'h5,
    IXD_PTR_LO = 4'h6,
    IXD_FIN    = 4'h7
  } ixd_state_t;

  function automatic logic [1:0] ixd_ext_count(input logic [7:0] pb);
    if (!pb[IXD_PB_SHORT] || pb[7:5] != IXD_PB_EXTTAG || pb[IXD_PB_ACC])
      return 2'h0;
    return pb[IXD_PB_LONG] ? 2'h2 : 2'h1;
  endfunction : ixd_ext_count

  function automatic logic [1:0] ixd_base_sel(input logic [7:0] pb);
    return (pb[IXD_PB_SHORT] && pb[7:5] == IXD_PB_EXTTAG) ? pb[4:3] : pb[7:6];
  endfunction : ixd_base_sel

  function automatic logic [1:0] ixd_lea_base(input logic [1:0] tgt);
    logic [1:0] b;
    b = IXD_BASE_STACK;
    if (tgt == IXD_LEA_FIRST) b = IXD_BASE_FIRST;
    if (tgt == IXD_LEA_SECOND) b = IXD_BASE_SECOND;
    return b;
  endfunction : ixd_lea_base

endpackage : ixd_pkg

/* File: hw/ixd_ea_calc.sv */
/*
  Combinational offset former and adder for one indexed postbyte.
  Assumes the postbyte, extension bytes and base value are held stable by the caller.
*/
`timescale 1ns/1ps
module ixd_ea_calc
  import ixd_pkg::*;
(
  // Decoded instruction bytes
  input  wire logic [7:0]  postbyte,
  input  wire logic [7:0]  ext_hi,
  input  wire logic [7:0]  ext_lo,
  // Operands
  input  wire logic [15:0] base,
  input  wire logic [7:0]  acc_a,
  input  wire logic [7:0]  acc_b,
  // Results
  output logic      [15:0] ea,
  output logic      [15:0] mod_value,
  output logic             is_auto,
  output logic             is_pre,
  output logic             is_indirect
);
  logic [15:0] step;
  logic [15:0] off;
  logic [15:0] sum;

  always_comb begin
    step = 16'h0000;
    off = 16'h0000;
    is_auto = 1'b0;
    is_pre = 1'b0;
    is_indirect = 1'b0;
    // Negative codes sign-extend directly; positive ones are biased so zero never occurs
    if (postbyte[3]) begin
      step = {12'hFFF, postbyte[3:0]};
    end else begin
      step = {12'h000, postbyte[3:0]} + 16'h0001;
    end
    if (!postbyte[IXD_PB_SHORT]) begin
      off = {{11{postbyte[4]}}, postbyte[4:0]};
    end else if (postbyte[7:5] != IXD_PB_EXTTAG) begin
      // Base field 11 here would be the extended tag, so PC can never be auto-modified
      is_auto = 1'b1;
      is_pre = !postbyte[IXD_PB_PRE];
      off = step;
    end else if (!postbyte[IXD_PB_ACC]) begin
      if (!postbyte[IXD_PB_LONG]) begin
        off = {{7{postbyte[0]}}, postbyte[0], ext_hi};
      end else begin
        off = {ext_hi, ext_lo};
      end
      is_indirect = postbyte[IXD_PB_LONG] & postbyte[0];
    end else begin
      unique case (postbyte[1:0])
        IXD_ACC_A: begin
          off = {8'h00, acc_a};
        end
        IXD_ACC_B: begin
          off = {8'h00, acc_b};
        end
        IXD_ACC_D, IXD_ACC_DIND: begin
          off = {acc_a, acc_b};
        end
      endcase
      is_indirect = (postbyte[1:0] == IXD_ACC_DIND);
    end
    sum = base + off;
    mod_value = is_auto ? sum : base;
    ea = (is_auto && !is_pre) ? base : sum;
  end

endmodule : ixd_ea_calc

/* File: hw/ixd_decoder.sv */
/*
  Indexed postbyte decoder: takes the postbyte and extension bytes, forms the
  effective address, fetches indirect pointers and reports register updates.
  Assumes the register file holds its values steady while a decode is busy,
  and that the byte stream, memory port and AHB-Lite master share hclk.
*/
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module ixd_decoder
  import ixd_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Decode request
  input  wire logic        dec_start,
  input  wire logic [1:0]  dec_lea,
  input  wire logic [15:0] pc_pb,
  output logic             dec_busy,
  // Instruction byte stream
  input  wire logic        ib_valid,
  input  wire logic [7:0]  ib_data,
  output logic             ib_ready,
  // Register file values
  input  wire logic [15:0] reg_first,
  input  wire logic [15:0] reg_second,
  input  wire logic [15:0] reg_stack,
  input  wire logic [7:0]  acc_a,
  input  wire logic [7:0]  acc_b,
  // Pointer read port
  output logic             mem_req,
  output logic      [15:0] mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  // Results
  output logic             ea_valid,
  output logic      [15:0] ea_addr,
  output logic             mod_valid,
  output logic      [1:0]  mod_sel,
  output logic      [15:0] mod_value,
  output logic             lea_valid,
  output logic      [1:0]  lea_sel,
  output logic      [15:0] lea_value
);

  typedef struct packed {
    ixd_state_t  st;
    logic [7:0]  pb;
    logic [7:0]  ext_hi;
    logic [7:0]  ext_lo;
    logic [1:0]  cnt;
    logic [1:0]  lea;
    logic [15:0] pc;
    logic [15:0] base;
    logic [15:0] ea;
    logic [15:0] modv;
    logic [7:0]  ptr_hi;
    logic        auto;
    logic        pre;
    logic        ind;
    logic        enable;
    logic [15:0] count;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
  } ixd_regs_t;

  ixd_regs_t s;
  ixd_regs_t next_s;

  logic [1:0]  bsel;
  logic [15:0] base_val;
  logic [15:0] c_ea;
  logic [15:0] c_mod;
  logic        c_auto;
  logic        c_pre;
  logic        c_ind;
  logic        fin;
  logic        is_lea;
  logic        lea_same;
  logic        ahb_take;
  logic [31:0] rd_mux;

  assign bsel = ixd_base_sel(s.pb);
  assign fin = (s.st == IXD_FIN);
  assign is_lea = (s.lea != IXD_LEA_NONE);
  assign lea_same = is_lea && (ixd_lea_base(s.lea) == bsel);
  assign ahb_take = hsel && hready && htrans[1];

  always_comb begin
    unique case (bsel)
      IXD_BASE_FIRST: begin
        base_val = reg_first;
      end
      IXD_BASE_SECOND: begin
        base_val = reg_second;
      end
      IXD_BASE_STACK: begin
        base_val = reg_stack;
      end
      IXD_BASE_PC: begin
        // PC points past the postbyte and every extension byte
        base_val = s.pc + 16'h0001 + {14'h0000, s.cnt};
      end
    endcase
  end

  ixd_ea_calc u_calc (
    .postbyte    (s.pb),
    .ext_hi      (s.ext_hi),
    .ext_lo      (s.ext_lo),
    .base        (base_val),
    .acc_a       (acc_a),
    .acc_b       (acc_b),
    .ea          (c_ea),
    .mod_value   (c_mod),
    .is_auto     (c_auto),
    .is_pre      (c_pre),
    .is_indirect (c_ind)
  );

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      IXD_CTRL_OFS: begin
        rd_mux[IXD_CTRL_EN] = s.enable;
      end
      IXD_STAT_OFS: begin
        rd_mux[IXD_ST_BUSY] = (s.st != IXD_IDLE);
        // Live state code lets software spot a fetch stalled on the byte stream
        rd_mux[7:4] = s.st;
        rd_mux[IXD_ST_IND] = s.ind;
        rd_mux[IXD_ST_AUTO] = s.auto;
      end
      IXD_EA_OFS: begin
        rd_mux[15:0] = s.ea;
      end
      IXD_CNT_OFS: begin
        rd_mux[15:0] = s.count;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
    if (haddr[31:8] != 24'h00_0000) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_comb begin
    next_s = s;
    // Register port: address phase captured here, write data lands one cycle later
    next_s.wr_pend = ahb_take && hwrite;
    next_s.wr_addr = haddr[7:0];
    if (ahb_take && !hwrite) begin
      next_s.rdata = rd_mux;
    end
    if (s.wr_pend && s.wr_addr == IXD_CTRL_OFS) begin
      next_s.enable = hwdata[IXD_CTRL_EN];
    end
    unique case (s.st)
      IXD_IDLE: begin
        if (dec_start && s.enable) begin
          next_s.lea = dec_lea;
          // Latched so the PC base cannot drift if the fetch pointer moves on
          next_s.pc = pc_pb;
          next_s.st = IXD_GET_PB;
        end
      end
      IXD_GET_PB: begin
        if (ib_valid) begin
          next_s.pb = ib_data;
          next_s.ext_hi = 8'h00;
          next_s.ext_lo = 8'h00;
          next_s.cnt = ixd_ext_count(ib_data);
          next_s.st = (ixd_ext_count(ib_data) == 2'h0) ? IXD_CALC : IXD_EXT1;
        end
      end
      IXD_EXT1: begin
        if (ib_valid) begin
          next_s.ext_hi = ib_data;
          next_s.st = (s.cnt == 2'h2) ? IXD_EXT2 : IXD_CALC;
        end
      end
      IXD_EXT2: begin
        if (ib_valid) begin
          next_s.ext_lo = ib_data;
          next_s.st = IXD_CALC;
        end
      end
      IXD_CALC: begin
        next_s.base = base_val;
        next_s.ea = c_ea;
        next_s.modv = c_mod;
        next_s.auto = c_auto;
        next_s.pre = c_pre;
        next_s.ind = c_ind;
        next_s.st = c_ind ? IXD_PTR_HI : IXD_FIN;
      end
      IXD_PTR_HI: begin
        if (mem_ack) begin
          next_s.ptr_hi = mem_rdata;
          next_s.st = IXD_PTR_LO;
        end
      end
      IXD_PTR_LO: begin
        if (mem_ack) begin
          next_s.ea = {s.ptr_hi, mem_rdata};
          next_s.st = IXD_FIN;
        end
      end
      IXD_FIN: begin
        next_s.count = s.count + 16'h0001;
        next_s.st = IXD_IDLE;
      end
      default: begin
        next_s.st = IXD_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.st <= IXD_IDLE;
      s.enable <= IXD_EN_RST;
    end else begin
      s <= next_s;
    end
  end

  // Zero-wait slave: every transfer completes in its first data-phase cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;

  assign dec_busy = (s.st != IXD_IDLE);
  assign ib_ready = (s.st == IXD_GET_PB) || (s.st == IXD_EXT1) || (s.st == IXD_EXT2);
  assign mem_req = (s.st == IXD_PTR_HI) || (s.st == IXD_PTR_LO);
  assign mem_addr = (s.st == IXD_PTR_LO) ? s.ea + 16'h0001 : s.ea;

  // Address-load instructions report the address instead of accessing memory
  assign ea_valid = fin && !is_lea;
  assign ea_addr = s.ea;
  assign lea_valid = fin && is_lea;
  assign lea_sel = ixd_lea_base(s.lea);
  assign lea_value = s.ea;
  // When the load target is the modified register, the load value wins
  assign mod_valid = fin && s.auto && !lea_same;
  assign mod_sel = bsel;
  assign mod_value = s.modv;

  short_no_ext_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_GET_PB && ib_valid && !ib_data[IXD_PB_SHORT]) |=> s.st == IXD_CALC)
    else $error("short form consumed an extension byte");

  long_two_ext_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_GET_PB && ib_valid && ib_data[7:5] == IXD_PB_EXTTAG
     && ib_data[2:1] == 2'h1) |=> s.st == IXD_EXT1 && s.cnt == 2'h2)
    else $error("long offset did not fetch two bytes");

  ext_second_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_EXT1 && ib_valid && s.cnt == 2'h2) |=> s.st == IXD_EXT2)
    else $error("second extension byte not fetched");

  ext_last_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_EXT2 && ib_valid) |=> s.st == IXD_CALC)
    else $error("extra byte fetched after two extensions");

  nine_one_ext_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_GET_PB && ib_valid && ib_data[7:5] == IXD_PB_EXTTAG
     && ib_data[2:1] == 2'h0) |=> s.st == IXD_EXT1 && s.cnt == 2'h1)
    else $error("nine-bit offset did not fetch one byte");

  acc_no_ext_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_GET_PB && ib_valid && ib_data[7:5] == IXD_PB_EXTTAG
     && ib_data[IXD_PB_ACC]) |=> s.st == IXD_CALC)
    else $error("accumulator form consumed an extension byte");

  ptr_endian_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_PTR_LO && mem_ack) |=> ea_addr == {$past(s.ptr_hi), $past(mem_rdata)})
    else $error("pointer bytes assembled in wrong order");

  ptr_next_byte_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_PTR_HI && mem_ack) |=> mem_addr == $past(mem_addr) + 16'h0001)
    else $error("second pointer byte not at next address");

  pc_base_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_CALC && bsel == IXD_BASE_PC)
      |-> base_val == pc_pb + 16'h0001 + {14'h0000, s.cnt})
    else $error("program counter base not past instruction end");

  no_pc_modify_a: assert property (@(posedge hclk) disable iff (!hresetn)
    mod_valid |-> mod_sel != IXD_BASE_PC)
    else $error("program counter auto-modified");

  const_keeps_base_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (fin && !s.auto) |-> !mod_valid && s.modv == s.base)
    else $error("constant form changed base register");

  pre_post_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (fin && s.auto) |-> (s.pre ? ea_addr == s.modv : ea_addr == s.base))
    else $error("pre or post modify used wrong address");

  step_nonzero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (fin && s.auto) |-> s.modv != s.base)
    else $error("auto-modify step of zero");

  // Offset checks recompute the sum from the sampled inputs; the pointer-read check compares against the adder output c_ea
  lea_no_access_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (dec_busy && is_lea) |-> !ea_valid)
    else $error("address-load produced a memory access");

  ind_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_CALC && c_ind) |=> mem_req && mem_addr == $past(c_ea))
    else $error("indirect form did not read the pointer");

  short_offset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_CALC && !s.pb[IXD_PB_SHORT])
      |=> ea_addr == $past(base_val) + {{11{$past(s.pb[4])}}, $past(s.pb[4:0])})
    else $error("short offset added wrongly");

  acc_unsigned_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == IXD_CALC && s.pb[7:5] == IXD_PB_EXTTAG && s.pb[2:0] == 3'h4)
      |=> ea_addr == $past(base_val) + {8'h00, $past(acc_a)})
    else $error("accumulator offset not unsigned");

  indirect_cov: cover property (@(posedge hclk) disable iff (!hresetn)
    s.st == IXD_PTR_LO && mem_ack);
  auto_cov: cover property (@(posedge hclk) disable iff (!hresetn) mod_valid);
  lea_cov: cover property (@(posedge hclk) disable iff (!hresetn) lea_valid);
  nine_bit_cov: cover property (@(posedge hclk) disable iff (!hresetn)
    fin && s.cnt == 2'h1);
  long_cov: cover property (@(posedge hclk) disable iff (!hresetn)
    fin && s.cnt == 2'h2 && !s.ind);

endmodule : ixd_decoder

/* File: tb/ixd_mem_model.sv */
/*
  Behavioural memory behind the decoder's pointer read port.
  Assumes one request at a time; a byte's value is derived from its address.
*/
`timescale 1ns/1ps
module ixd_mem_model (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Answer speed
  input  wire logic        slow,
  // Pointer read port
  input  wire logic        mem_req,
  input  wire logic [15:0] mem_addr,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata
);
  logic [2:0] wait_cnt;

  // Address-derived bytes let the bench predict pointers without a data table.
  // Between requests and after each answer the data lines toggle so that stale bytes never look valid; wait cycles hold them.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack   <= 1'h0;
      mem_rdata <= 8'hA5;
      wait_cnt  <= 3'h0;
    end else if (mem_ack || !mem_req) begin
      mem_ack   <= 1'h0;
      mem_rdata <= ~mem_rdata;
      wait_cnt  <= 3'h0;
    end else if (!slow || wait_cnt == 3'h3) begin
      mem_ack   <= 1'h1;
      mem_rdata <= mem_addr[15:8] ^ mem_addr[7:0];
    end else begin
      wait_cnt  <= wait_cnt + 3'h1;
    end
  end
endmodule : ixd_mem_model

/* File: tb/testbench.sv */
/*
  Self-checking bench for the indexed postbyte decoder.
  Assumes the memory model answers pointer reads and the bench plays byte stream and bus master.
*/
`timescale 1ns/1ps
module testbench;
  import ixd_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, dec_start, ib_valid, slow;
  logic        hreadyout, hresp, dec_busy, ib_ready, mem_req, mem_ack;
  logic        ea_valid, mod_valid, lea_valid;
  logic [1:0]  htrans, dec_lea, mod_sel, lea_sel;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] pc_pb, reg_first, reg_second, reg_stack, mem_addr;
  logic [15:0] ea_addr, mod_value, lea_value;
  logic [7:0]  ib_data, acc_a, acc_b, mem_rdata;
  int          mismatches, n_compared, cycles, n_dec;

  ixd_decoder i_ixd_decoder (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dec_start(dec_start),
    .dec_lea(dec_lea), .pc_pb(pc_pb), .dec_busy(dec_busy), .ib_valid(ib_valid),
    .ib_data(ib_data), .ib_ready(ib_ready), .reg_first(reg_first), .reg_second(reg_second),
    .reg_stack(reg_stack), .acc_a(acc_a), .acc_b(acc_b), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ea_valid(ea_valid),
    .ea_addr(ea_addr), .mod_valid(mod_valid), .mod_sel(mod_sel), .mod_value(mod_value),
    .lea_valid(lea_valid), .lea_sel(lea_sel), .lea_value(lea_value));
  ixd_mem_model i_ixd_mem_model (.hclk(hclk), .hresetn(hresetn), .slow(slow),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    hclk = 1'h0;
    forever #12.5 hclk = ~hclk;
  end

  task give_verdict;
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  // A whole run takes a few hundred cycles; the ceiling leaves ample slack
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
    chk("bus response", 32'h0, {31'h0, hresp});
  endtask : ahb

  task run(input logic [7:0] pb, e1, e2, input int nx, input logic [1:0] lea,
           input logic [15:0] exp, input logic mv, input logic [1:0] ms,
           input logic [15:0] mval);
    logic [7:0] b[3];
    b[0] = pb;
    b[1] = e1;
    b[2] = e2;
    @(posedge hclk);
    dec_start <= 1'h1;
    dec_lea   <= lea;
    @(posedge hclk);
    dec_start <= 1'h0;
    for (int i = 0; i <= nx; i++) begin
      ib_valid <= 1'h1;
      ib_data  <= b[i];
      do @(negedge hclk); while (ib_ready !== 1'h1);
      @(posedge hclk);
    end
    ib_valid <= 1'h0;
    ib_data  <= ~b[nx];
    do @(negedge hclk); while (ea_valid !== 1'h1 && lea_valid !== 1'h1);
    n_dec++;
    chk("busy during decode", 32'h1, {31'h0, dec_busy});
    chk("operand pulse", {31'h0, lea == 2'h0}, {31'h0, ea_valid});
    chk("address", {16'h0, exp}, {16'h0, lea == 2'h0 ? ea_addr : lea_value});
    if (lea != 2'h0)
      chk("load target", {30'h0, lea == 2'h1, lea == 2'h3}, {30'h0, lea_sel});
    chk("writeback pulse", {31'h0, mv}, {31'h0, mod_valid});
    if (mv) begin
      chk("writeback reg", {30'h0, ms}, {30'h0, mod_sel});
      chk("writeback value", {16'h0, mval}, {16'h0, mod_value});
    end
  endtask : run

  initial begin
    {hsel, hwrite, dec_start, ib_valid, slow, hresetn} = 6'h0;
    {htrans, dec_lea, hsize} = 7'h2;
    {haddr, hwdata} = 64'h0;
    ib_data = 8'h5A;
    pc_pb = 16'h4000;
    reg_first = 16'h1000;
    reg_second = 16'h2000;
    reg_stack = 16'h3000;
    acc_a = 8'h85;
    acc_b = 8'h7F;
    repeat (2) @(posedge hclk);
    hresetn <= 1'h1;
    ahb(1'h0, IXD_CTRL_OFS, 32'h0);
    chk("enable at reset", 32'h1, rd);
    ahb(1'h1, IXD_CTRL_OFS, 32'h0);
    @(posedge hclk);
    dec_start <= 1'h1;
    repeat (4) @(negedge hclk);
    chk("busy while disabled", 32'h0, {31'h0, dec_busy});
    @(posedge hclk);
    dec_start <= 1'h0;
    ahb(1'h1, IXD_CTRL_OFS, 32'h1);
    run(8'h00, 8'h00, 8'h00, 0, 2'h0, 16'h1000, 1'h0, 2'h0, 16'h0);
    run(8'h58, 8'h00, 8'h00, 0, 2'h0, 16'h1FF8, 1'h0, 2'h0, 16'h0);
    run(8'h8F, 8'h00, 8'h00, 0, 2'h0, 16'h300F, 1'h0, 2'h0, 16'h0);
    run(8'hD0, 8'h00, 8'h00, 0, 2'h0, 16'h3FF1, 1'h0, 2'h0, 16'h0);
    run(8'hE0, 8'hFF, 8'h00, 1, 2'h0, 16'h10FF, 1'h0, 2'h0, 16'h0);
    run(8'hE9, 8'hEC, 8'h00, 1, 2'h0, 16'h1FEC, 1'h0, 2'h0, 16'h0);
    run(8'hF9, 8'h00, 8'h00, 1, 2'h0, 16'h3F02, 1'h0, 2'h0, 16'h0);
    run(8'hE2, 8'hFF, 8'hFF, 2, 2'h0, 16'h0FFF, 1'h0, 2'h0, 16'h0);
    run(8'hEA, 8'h12, 8'h34, 2, 2'h0, 16'h3234, 1'h0, 2'h0, 16'h0);
    run(8'hFA, 8'h00, 8'h10, 2, 2'h0, 16'h4013, 1'h0, 2'h0, 16'h0);
    run(8'hE3, 8'h00, 8'h0A, 2, 2'h0, 16'h1A1B, 1'h0, 2'h0, 16'h0);
    run(8'hE4, 8'h00, 8'h00, 0, 2'h0, 16'h1085, 1'h0, 2'h0, 16'h0);
    run(8'hED, 8'h00, 8'h00, 0, 2'h0, 16'h207F, 1'h0, 2'h0, 16'h0);
    run(8'hF6, 8'h00, 8'h00, 0, 2'h0, 16'hB57F, 1'h0, 2'h0, 16'h0);
    run(8'hFE, 8'h00, 8'h00, 0, 2'h0, 16'hC580, 1'h0, 2'h0, 16'h0);
    run(8'hEF, 8'h00, 8'h00, 0, 2'h0, 16'hDA25, 1'h0, 2'h0, 16'h0);
    ahb(1'h0, IXD_STAT_OFS, 32'h0);
    chk("indirect flag", 32'h1, {31'h0, rd[IXD_ST_IND]});
    // A slow memory must not change which bytes form the pointer
    slow <= 1'h1;
    run(8'hFB, 8'h00, 8'h02, 2, 2'h0, 16'h4546, 1'h0, 2'h0, 16'h0);
    slow <= 1'h0;
    run(8'hAF, 8'h00, 8'h00, 0, 2'h0, 16'h2FFF, 1'h1, 2'h2, 16'h2FFF);
    run(8'h31, 8'h00, 8'h00, 0, 2'h0, 16'h1000, 1'h1, 2'h0, 16'h1002);
    run(8'h67, 8'h00, 8'h00, 0, 2'h0, 16'h2008, 1'h1, 2'h1, 16'h2008);
    run(8'h78, 8'h00, 8'h00, 0, 2'h0, 16'h2000, 1'h1, 2'h1, 16'h1FF8);
    ahb(1'h0, IXD_STAT_OFS, 32'h0);
    chk("auto flag", 32'h1, {31'h0, rd[IXD_ST_AUTO]});
    chk("idle status", 32'h0, {31'h0, rd[IXD_ST_BUSY]});
    run(8'h31, 8'h00, 8'h00, 0, 2'h2, 16'h1000, 1'h0, 2'h0, 16'h0);
    run(8'h8F, 8'h00, 8'h00, 0, 2'h1, 16'h300F, 1'h0, 2'h0, 16'h0);
    run(8'hAF, 8'h00, 8'h00, 0, 2'h3, 16'h2FFF, 1'h1, 2'h2, 16'h2FFF);
    @(posedge hclk);
    reg_first <= 16'hFFFC;
    run(8'h0F, 8'h00, 8'h00, 0, 2'h0, 16'h000B, 1'h0, 2'h0, 16'h0);
    run(8'h27, 8'h00, 8'h00, 0, 2'h0, 16'h0004, 1'h1, 2'h0, 16'h0004);
    ahb(1'h0, IXD_CNT_OFS, 32'h0);
    chk("decode count", n_dec, rd);
    ahb(1'h1, IXD_CNT_OFS, 32'hFFFF);
    ahb(1'h0, IXD_CNT_OFS, 32'h0);
    chk("count after write", n_dec, rd);
    ahb(1'h0, 8'h10, 32'h0);
    chk("unmapped read", 32'h0, rd);
    give_verdict();
  end
endmodule : testbench
